// ---- input_capture_channel.sv ----
// one input capture channel with an apb register slave
// assumes timebase counts arrive on pclk; the capture pin is asynchronous
`timescale 1ns/1ps
module input_capture_channel #(
    parameter int width = capture_pkg::capture_width,
    parameter int depth = capture_pkg::buffer_depth
) (
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // capture pin and timebases
    input  wire logic              capture_pin,
    input  wire logic [width-1:0]  timebase_a,
    input  wire logic [width-1:0]  timebase_b,
    // cpu power state
    input  wire logic              cpu_idle,
    input  wire logic              cpu_sleep,
    // interrupt and wake
    output logic                   channel_irq_req,
    output logic                   wake_req
);

    initial begin
        if (width != capture_pkg::capture_width || depth < 2) begin
            $error("input_capture_channel: unsupported width or depth");
        end
    end

    // configuration and status state
    capture_pkg::control_type ctrl;
    capture_pkg::control_type next_ctrl;
    logic                     capture_overrun_flag;
    logic                     next_overrun;
    logic                     overrun_lock;
    logic                     next_lock;
    logic                     channel_irq_flag;
    logic                     next_irq_flag;
    logic                     irq_enable;
    logic                     next_irq_enable;

    // edge path state
    logic                     pin_meta;
    logic                     pin_sync;
    logic                     pin_prev;
    logic [3:0]               prescale;
    logic [3:0]               next_prescale;
    logic [1:0]               event_count;
    logic [1:0]               next_event_count;

    // apb answer, interrupt request and wake state
    logic [31:0]              next_prdata;
    logic                     next_pready;
    logic                     next_pslverr;
    logic                     next_irq_req;
    logic                     next_wake;

    // decoded signals
    logic                     rise;
    logic                     fall;
    logic                     running;
    logic                     irq_only;
    logic                     qualified;
    logic                     store_event;
    logic                     irq_event;
    logic                     fifo_ready;
    logic                     fifo_valid;
    logic                     push;
    logic [width-1:0]         head;
    logic [width-1:0]         selected_time;
    logic                     access;
    logic                     wr_ctrl;
    logic                     wr_irq;
    logic                     rd_buffer;
    logic                     mapped;

    capture_pkg::capture_mode_sel_type mode;

    assign mode = ctrl.capture_mode_sel;

    // two stage synchroniser, then an edge register fed from the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
            pin_prev <= 1'b0;
        end else begin
            pin_meta <= capture_pin;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    assign rise = pin_sync && !pin_prev;
    assign fall = !pin_sync && pin_prev;

    // channel works unless off or unused (110), stopped in idle, or asleep outside mode 111
    assign running = (mode != capture_pkg::mode_off)
                  && (mode != capture_pkg::mode_unused)
                  && !(cpu_idle && ctrl.idle_stop_bit)
                  && !(cpu_sleep && mode != capture_pkg::mode_irq_rise);

    // mode 111 in sleep or idle serves only as an external interrupt
    assign irq_only = (mode == capture_pkg::mode_irq_rise) && (cpu_sleep || cpu_idle);

    // edge qualification per capture mode
    always_comb begin
        qualified = 1'b0;
        unique case (mode)
            capture_pkg::mode_both:     qualified = rise || fall;
            capture_pkg::mode_fall:     qualified = fall;
            capture_pkg::mode_rise:     qualified = rise;
            capture_pkg::mode_rise_4:   qualified = rise && prescale == capture_pkg::every_4th_last;
            capture_pkg::mode_rise_16:  qualified = rise && prescale == capture_pkg::every_16th_last;
            capture_pkg::mode_irq_rise: qualified = rise;
            capture_pkg::mode_off:      qualified = 1'b0;
            capture_pkg::mode_unused:   qualified = 1'b0;
        endcase
        qualified = qualified && running;
    end

    // edge prescaler counts rising edges in the divided modes only
    always_comb begin
        next_prescale = prescale;
        if (mode == capture_pkg::mode_off) begin
            next_prescale = '0;
        end else if (running && rise && (mode == capture_pkg::mode_rise_4
                                      || mode == capture_pkg::mode_rise_16)) begin
            next_prescale = qualified ? 4'h0 : prescale + 4'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale <= '0;
        end else begin
            prescale <= next_prescale;
        end
    end

    // timebase b is the reset choice; a is taken when the select bit is set
    assign selected_time = ctrl.timebase_select_bit ? timebase_a : timebase_b;

    assign store_event = qualified && !irq_only;
    assign push        = store_event && !overrun_lock && fifo_ready;

    capture_fifo #(
        .width (width),
        .depth (depth)
    ) u_fifo (
        .pclk       (pclk),
        .presetn    (presetn),
        .push_valid (push),
        .push_data  (selected_time),
        .push_ready (fifo_ready),
        .pop        (rd_buffer),
        .pop_valid  (fifo_valid),
        .head       (head)
    );

    // apb decode: a transfer completes at the access edge with pready high
    assign access    = psel && penable && pready;
    assign mapped    = paddr == capture_pkg::ctrl_addr || paddr == capture_pkg::buffer_addr
                    || paddr == capture_pkg::irq_addr;
    assign wr_ctrl   = access && pwrite && paddr == capture_pkg::ctrl_addr;
    assign wr_irq    = access && pwrite && paddr == capture_pkg::irq_addr;
    assign rd_buffer = access && !pwrite && paddr == capture_pkg::buffer_addr;

    // overrun detection and lock, set wins over a software clear
    always_comb begin
        next_overrun = capture_overrun_flag;
        next_lock    = overrun_lock;
        if (wr_ctrl && !pwdata[capture_pkg::overrun_bit]) begin
            next_overrun = 1'b0;
        end
        if (overrun_lock && !fifo_valid) begin
            next_lock = 1'b0;
        end
        if (store_event && !overrun_lock && !fifo_ready
            && mode != capture_pkg::mode_both) begin
            next_overrun = 1'b1;
            next_lock    = 1'b1;
        end
    end

    // events per interrupt: count stored captures, every capture in 001 and 111
    always_comb begin
        irq_event        = 1'b0;
        next_event_count = event_count;
        if (mode == capture_pkg::mode_off) begin
            next_event_count = '0;
        end
        if (irq_only && qualified) begin
            irq_event = 1'b1;
        end else if (push || (store_event && mode == capture_pkg::mode_both)) begin
            if (mode == capture_pkg::mode_both || mode == capture_pkg::mode_irq_rise) begin
                irq_event = 1'b1;
            end else if (event_count == ctrl.irq_event_count) begin
                irq_event        = 1'b1;
                next_event_count = '0;
            end else begin
                next_event_count = event_count + 2'h1;
            end
        end
    end

    // control and interrupt registers, flag set wins over its clear
    always_comb begin
        next_ctrl       = ctrl;
        next_irq_flag   = channel_irq_flag;
        next_irq_enable = irq_enable;
        if (wr_ctrl) begin
            next_ctrl.idle_stop_bit       = pwdata[capture_pkg::idle_stop_pos];
            next_ctrl.timebase_select_bit = pwdata[capture_pkg::timebase_bit];
            next_ctrl.irq_event_count     = pwdata[capture_pkg::irq_count_lsb +: 2];
            next_ctrl.capture_mode_sel    =
                capture_pkg::capture_mode_sel_type'(pwdata[capture_pkg::mode_lsb +: 3]);
        end
        if (wr_irq) begin
            next_irq_enable = pwdata[capture_pkg::irq_enable_bit];
            if (pwdata[capture_pkg::irq_flag_bit]) begin
                next_irq_flag = 1'b0;
            end
        end
        if (irq_event) begin
            next_irq_flag = 1'b1;
        end
    end

    // interrupt request and one cycle wake pulse
    always_comb begin
        next_irq_req = next_irq_flag && next_irq_enable;
        next_wake    = irq_event && irq_enable && (cpu_sleep || cpu_idle);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl                 <= capture_pkg::control_reset;
            capture_overrun_flag <= 1'b0;
            overrun_lock         <= 1'b0;
            channel_irq_flag     <= 1'b0;
            irq_enable           <= 1'b0;
            event_count          <= '0;
            channel_irq_req      <= 1'b0;
            wake_req             <= 1'b0;
        end else begin
            ctrl                 <= next_ctrl;
            capture_overrun_flag <= next_overrun;
            overrun_lock         <= next_lock;
            channel_irq_flag     <= next_irq_flag;
            irq_enable           <= next_irq_enable;
            event_count          <= next_event_count;
            channel_irq_req      <= next_irq_req;
            wake_req             <= next_wake;
        end
    end

    // apb answer prepared in the setup cycle, shown in the access cycle
    always_comb begin
        next_prdata  = '0;
        next_pready  = 1'b0;
        next_pslverr = 1'b0;
        if (psel && !penable) begin
            next_pready  = 1'b1;
            next_pslverr = !mapped;
            if (!pwrite) begin
                unique case (paddr)
                    capture_pkg::ctrl_addr: begin
                        next_prdata[capture_pkg::idle_stop_pos]      = ctrl.idle_stop_bit;
                        next_prdata[capture_pkg::timebase_bit]       = ctrl.timebase_select_bit;
                        next_prdata[capture_pkg::irq_count_lsb +: 2] = ctrl.irq_event_count;
                        next_prdata[capture_pkg::overrun_bit]        = capture_overrun_flag;
                        next_prdata[capture_pkg::nonempty_bit]       = fifo_valid;
                        next_prdata[capture_pkg::mode_lsb +: 3]      = ctrl.capture_mode_sel;
                    end
                    capture_pkg::buffer_addr: begin
                        next_prdata[width-1:0] = head;
                    end
                    capture_pkg::irq_addr: begin
                        next_prdata[capture_pkg::irq_flag_bit]   = channel_irq_flag;
                        next_prdata[capture_pkg::irq_enable_bit] = irq_enable;
                    end
                    default: begin
                        next_prdata = '0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end

endmodule

// ---- capture_pkg.sv ----
// constants, field layouts and carrier types for one input capture channel
// assumes a 40 mhz apb clock and a single capture pin per channel
package capture_pkg;

    // register byte addresses
    localparam logic [11:0] ctrl_addr   = 12'h000;
    localparam logic [11:0] buffer_addr = 12'h004;
    localparam logic [11:0] irq_addr    = 12'h008;

    // control register field positions
    localparam int mode_lsb        = 0;
    localparam int nonempty_bit    = 3;
    localparam int overrun_bit     = 4;
    localparam int irq_count_lsb   = 5;
    localparam int timebase_bit    = 7;
    localparam int idle_stop_pos   = 13;

    // irq register field positions
    localparam int irq_flag_bit    = 0;
    localparam int irq_enable_bit  = 1;

    // capture buffer shape
    localparam int buffer_depth    = 4;
    localparam int capture_width   = 16;

    // edge prescaler terminal counts
    localparam logic [3:0] every_4th_last  = 4'h3;
    localparam logic [3:0] every_16th_last = 4'hf;

    // capture mode encodings
    typedef enum logic [2:0] {
        mode_off      = 3'h0,
        mode_both     = 3'h1,
        mode_fall     = 3'h2,
        mode_rise     = 3'h3,
        mode_rise_4   = 3'h4,
        mode_rise_16  = 3'h5,
        mode_unused   = 3'h6,
        mode_irq_rise = 3'h7
    } capture_mode_sel_type;

    // software control fields of the channel
    typedef struct packed {
        logic                 idle_stop_bit;
        logic                 timebase_select_bit;
        logic [1:0]           irq_event_count;
        capture_mode_sel_type capture_mode_sel;
    } control_type;

    localparam control_type control_reset = '{1'b0, 1'b0, 2'h0, mode_off};

endpackage

// ---- capture_fifo.sv ----
// four word shift buffer for captured timebase values
// assumes push and pop come from logic on the same clock
`timescale 1ns/1ps
module capture_fifo #(
    parameter int width = capture_pkg::capture_width,
    parameter int depth = capture_pkg::buffer_depth
) (
    // clock and reset
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    // filling side
    input  wire logic                     push_valid,
    input  wire logic [width-1:0]         push_data,
    output logic                          push_ready,
    // draining side
    input  wire logic                     pop,
    output logic                          pop_valid,
    output logic [width-1:0]              head
);

    initial begin
        if (depth < 2 || width < 1) begin
            $error("capture_fifo: depth must be at least 2");
        end
    end

    logic [width-1:0]          entry [depth];
    logic [width-1:0]          next_entry [depth];
    logic [$clog2(depth+1)-1:0] fill;
    logic [$clog2(depth+1)-1:0] next_fill;
    logic                      do_push;
    logic                      do_pop;

    assign push_ready = (fill != depth[$clog2(depth+1)-1:0]);
    assign pop_valid  = (fill != '0);
    assign head       = entry[0];
    assign do_push    = push_valid && push_ready;
    assign do_pop     = pop && pop_valid;

    // pop shifts every entry one place toward the head, push lands after the last
    always_comb begin
        next_fill = fill;
        for (int i = 0; i < depth; i++) begin
            next_entry[i] = entry[i];
        end
        if (do_pop) begin
            for (int i = 0; i < depth - 1; i++) begin
                next_entry[i] = entry[i+1];
            end
            next_fill = fill - 1'b1;
        end
        if (do_push) begin
            next_entry[next_fill[$clog2(depth)-1:0]] = push_data;
            next_fill = next_fill + 1'b1;
        end
    end

    // register the buffer state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fill <= '0;
            for (int i = 0; i < depth; i++) begin
                entry[i] <= '0;
            end
        end else begin
            fill <= next_fill;
            for (int i = 0; i < depth; i++) begin
                entry[i] <= next_entry[i];
            end
        end
    end

endmodule

// ---- capture_source.sv ----
// model of the external digital signal on the capture pin
// assumes toggle requests arrive on pclk one at a time, spaced by the bench
`timescale 1ns/1ps
module capture_source (
    // clock
    input  wire logic       pclk,
    // toggle request and its delay in cycles, prompt or slow
    input  wire logic       toggle_req,
    input  wire logic [3:0] delay,
    // driven pin, push-pull, holds its level between toggles
    output logic            capture_pin
);
    int wait_cnt = -1;

    initial capture_pin = 1'b0;

    // the level changes once the requested delay has run out
    always @(posedge pclk) begin
        if (toggle_req) begin
            wait_cnt <= int'(delay);
        end else if (wait_cnt == 0) begin
            capture_pin <= ~capture_pin;
            wait_cnt    <= -1;
        end else if (wait_cnt > 0) begin
            wait_cnt <= wait_cnt - 1;
        end
    end
endmodule

// ---- input_capture_channel_asserts.sv ----
// concurrent checks on the ports of the capture channel
// assumes one pclk domain and an asynchronous active low reset
`timescale 1ns/1ps
module input_capture_channel_asserts #(
    parameter int width = capture_pkg::capture_width,
    parameter int depth = capture_pkg::buffer_depth
) (
    // clock and reset
    input wire logic             pclk,
    input wire logic             presetn,
    // apb slave
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [11:0]      paddr,
    input wire logic [31:0]      pwdata,
    input wire logic [31:0]      prdata,
    input wire logic             pready,
    input wire logic             pslverr,
    // capture pin and timebases
    input wire logic             capture_pin,
    input wire logic [width-1:0] timebase_a,
    input wire logic [width-1:0] timebase_b,
    // power state, interrupt and wake
    input wire logic             cpu_idle,
    input wire logic             cpu_sleep,
    input wire logic             channel_irq_req,
    input wire logic             wake_req
);
    logic [3:0] pin_age;
    logic [3:0] next_pin_age;
    logic       pin_prev;
    logic       mapped;

    default clocking main_cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // address decode of the three registers
    assign mapped = paddr inside {capture_pkg::ctrl_addr, capture_pkg::buffer_addr,
                                  capture_pkg::irq_addr};

    // cycles since the pin last changed, saturating at 15
    always_comb begin
        next_pin_age = (pin_age == 4'hf) ? pin_age : pin_age + 4'h1;
        if (capture_pin != pin_prev) begin
            next_pin_age = 4'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_age  <= 4'hf;
            pin_prev <= 1'b0;
        end else begin
            pin_age  <= next_pin_age;
            pin_prev <= capture_pin;
        end
    end

    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no pready in the access cycle");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held past one cycle");
    a_err_decode: assert property (psel && !penable |=> pslverr == !$past(mapped))
        else $error("pslverr does not follow the address decode");
    a_idle_data_zero: assert property (!pready |-> prdata == 32'h0 && !pslverr)
        else $error("read data or error outside the access cycle");
    a_err_reads_zero: assert property (pslverr |-> prdata == 32'h0)
        else $error("unmapped read returned data");
    a_wake_pulse: assert property (wake_req |=> !wake_req)
        else $error("wake request longer than one cycle");
    a_wake_low_power: assert property (wake_req |-> $past(cpu_idle || cpu_sleep))
        else $error("wake request while the cpu is awake");
    a_wake_needs_edge: assert property (wake_req |-> pin_age <= 4'h8)
        else $error("wake request without a recent pin edge");
    a_irq_has_cause: assert property ($rose(channel_irq_req) |->
        pin_age <= 4'h8 || $past(pready && pwrite) || $past(pready && pwrite, 2))
        else $error("interrupt raised without an edge or a write");
    a_irq_disable: assert property (pready && pwrite && paddr == capture_pkg::irq_addr
        && !pwdata[capture_pkg::irq_enable_bit] |=> ##1 !channel_irq_req)
        else $error("interrupt request stays up after disable");

    c_wake: cover property (wake_req);
    c_unmapped: cover property (pslverr);
    c_irq: cover property ($rose(channel_irq_req));
endmodule

bind input_capture_channel input_capture_channel_asserts #(.width(width), .depth(depth)) u_asserts (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_pin(capture_pin), .timebase_a(timebase_a), .timebase_b(timebase_b),
    .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep), .channel_irq_req(channel_irq_req),
    .wake_req(wake_req)
);

// ---- input_capture_channel_bench.sv ----
// self-checking bench for one capture channel and its pin source model
// assumes the apb slave answers in its own time, bounded by the cycle ceiling
`timescale 1ns/1ps
module input_capture_channel_bench;
    localparam logic [11:0] ctrl_a = capture_pkg::ctrl_addr;
    localparam logic [11:0] buf_a  = capture_pkg::buffer_addr;
    localparam logic [11:0] irq_a  = capture_pkg::irq_addr;
    localparam logic [2:0]  modes [8] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7, 3'h0, 3'h6};
    localparam int          togs [8]  = '{10, 6, 12, 10, 34, 6, 4, 4};
    // mode, idle, sleep, idle stop, irq enable
    localparam logic [6:0]  lp [6] = '{7'h75, 7'h74, 7'h79, 7'h35, 7'h39, 7'h3b};
    logic        pclk, presetn, psel, penable, pwrite, capture_pin, toggle_req, err;
    logic        cpu_idle, cpu_sleep, pready, pslverr, channel_irq_req, wake_req;
    logic        idle_b, sleep_b, stop_b, en_b, tsel, pin_lvl, locked, ovf, track;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, cv;
    logic [15:0] tb_a, tb_b;
    logic [15:0] q [$];
    logic [3:0]  delay;
    logic [2:0]  mode;
    logic [1:0]  n, ex;
    int          n_mismatch, checks_done, cyc, presc, wakes, stored, w;

    input_capture_channel u_input_capture_channel (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .capture_pin(capture_pin), .timebase_a(tb_a), .timebase_b(tb_b),
        .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep), .channel_irq_req(channel_irq_req),
        .wake_req(wake_req));
    capture_source u_capture_source (
        .pclk(pclk), .toggle_req(toggle_req), .delay(delay), .capture_pin(capture_pin));

    // 40 mhz clock
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // cycle ceiling and wake pulse counter
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (wake_req === 1'b1) begin
            wakes <= wakes + 1;
        end
        if (cyc == 40000) begin
            n_mismatch++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // edge qualification of the mode in force, with the bench's own prescaler
    function automatic bit qual(input bit rise);
        case (mode)
            3'h1: return 1'b1;
            3'h2: return !rise;
            3'h3, 3'h7: return rise;
            3'h4, 3'h5: begin
                presc += int'(rise);
                if (presc == ((mode == 3'h4) ? 4 : 16)) begin
                    presc = 0;
                    return 1'b1;
                end
            end
            default: ;
        endcase
        return 1'b0;
    endfunction

    // expected buffer effect of one qualified edge
    function automatic void store(input logic [15:0] v);
        if (locked) begin
            return;
        end
        if (q.size() < 4) begin
            q.push_back(v);
            stored++;
        end else if (mode != 3'h1) begin
            ovf    = 1'b1;
            locked = 1'b1;
        end
    endfunction

    // {wake, store} for a low power row
    function automatic logic [1:0] lp_expect(input logic [6:0] r);
        logic act;
        act = r[2] ? (r[6:4] == 3'h7) : !(r[3] && r[1]);
        return {act && r[0], act && r[6:4] != 3'h7};
    endfunction

    // one pin toggle with fresh timebase values
    task automatic tog();
        pin_lvl = ~pin_lvl;
        tb_a       <= 16'($urandom);
        tb_b       <= 16'($urandom);
        delay      <= 4'($urandom_range(2, 6));
        toggle_req <= 1'b1;
        @(posedge pclk);
        toggle_req <= 1'b0;
        repeat (18) @(posedge pclk);
        if (track && qual(pin_lvl)) begin
            store(tsel ? tb_a : tb_b);
        end
    endtask

    task automatic pop_chk();
        apb(1'b0, buf_a, 32'h0);
        chk("buffer", rd, {16'h0, q.pop_front()});
        if (q.size() == 0) begin
            locked = 1'b0;
        end
    endtask

    // main sequence
    initial begin
        {psel, penable, pwrite, toggle_req, cpu_idle, cpu_sleep, pin_lvl} = '0;
        {paddr, pwdata, tb_a, tb_b, delay} = '0;
        presetn = 1'b0;
        void'($urandom(32'h1947));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, ctrl_a, 32'h0);
        chk("ctrl reset", rd, 32'h0);
        apb(1'b0, irq_a, 32'h0);
        chk("irq reset", rd, 32'h0);
        apb(1'b0, 12'h00c, 32'h0);
        chk("unmapped", {rd[30:0], err}, 32'h1);
        track = 1'b1;
        foreach (modes[i]) begin
            mode   = modes[i];
            tsel   = 1'($urandom);
            n      = (mode == 3'h1) ? 2'($urandom) : 2'h0;
            stored = 0;
            ovf    = 1'b0;
            presc  = 0;
            cv     = {24'h0, tsel, n, 2'h0, mode};
            apb(1'b1, ctrl_a, 32'h0);
            apb(1'b1, ctrl_a, cv);
            apb(1'b1, irq_a, 32'h3);
            repeat (togs[i]) tog();
            apb(1'b0, ctrl_a, 32'h0);
            chk("ctrl", rd, cv | {27'h0, ovf, q.size() != 0, 3'h0});
            chk("irq", 32'(channel_irq_req), 32'(stored > 0));
            if (q.size() > 0) begin
                pop_chk();
                tog();
                tog();
            end
            while (q.size() > 0) begin
                pop_chk();
            end
            apb(1'b0, ctrl_a, 32'h0);
            chk("drained", 32'(rd[3]), 32'h0);
        end
        track = 1'b0;
        foreach (lp[i]) begin
            {mode, idle_b, sleep_b, stop_b, en_b} = lp[i];
            ex = lp_expect(lp[i]);
            apb(1'b1, ctrl_a, 32'h0);
            apb(1'b1, ctrl_a, {18'h0, stop_b, 10'h0, mode});
            apb(1'b1, irq_a, {30'h0, en_b, 1'b1});
            cpu_idle  <= idle_b;
            cpu_sleep <= sleep_b;
            w = wakes;
            tog();
            tog();
            cpu_idle  <= 1'b0;
            cpu_sleep <= 1'b0;
            chk("wake", 32'(wakes - w), 32'(ex[1]));
            apb(1'b0, ctrl_a, 32'h0);
            chk("stored", 32'(rd[3]), 32'(ex[0]));
            if (rd[3] === 1'b1) begin
                apb(1'b0, buf_a, 32'h0);
            end
        end
        finish_test();
    end
endmodule
